// ### rtl/qfp_params.svh
// offsets, field positions and reset values of the queue frame data port
`ifndef QFP_PARAMS_SVH
`define QFP_PARAMS_SVH

// register indices; the byte address on the bus is four times the index
`define QFP_IDX_TXCMD  8'h00
`define QFP_IDX_RXCMD  8'h02
`define QFP_IDX_TXPTR  8'h04
`define QFP_IDX_RXPTR  8'h06
`define QFP_IDX_DATLO  8'h08
`define QFP_IDX_DATHI  8'h0A
`define QFP_IDX_RDBYTE 8'h0C
`define QFP_ADDR(idx)  ((idx) << 2)

// pointer register fields
`define QFP_PTR_W      11
`define QFP_PTR_MSB    10
`define QFP_AI_BIT     14
`define QFP_PTR_RST    11'h000
`define QFP_AI_RST     1'b0

// command register field
`define QFP_CMD_BIT    0

// bus responses
`define QFP_RESP_OKAY   2'h0
`define QFP_RESP_SLVERR 2'h2
`define QFP_RESP_DECERR 2'h3

`endif

// ### rtl/qfp_pkg.sv
// types and access-size helpers shared by the queue frame data port
package qfp_pkg;

  typedef enum logic [1:0] {
    QFP_SZ_NONE,
    QFP_SZ_BYTE,
    QFP_SZ_WORD,
    QFP_SZ_DWORD
  } qfp_size_t;

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        tx_ai;
    logic [10:0] tx_ptr;
    logic        rx_ai;
    logic [10:0] rx_ptr;
  } qfp_state_t;

  typedef struct packed {
    logic busy;
    logic req;
  } qfp_cmd_state_t;

  // access size from the byte strobes; split lanes are not an access
  function automatic qfp_size_t qfp_strb_size(input logic [3:0] strb);
    case (strb)
      4'h1, 4'h2, 4'h4, 4'h8: qfp_strb_size = QFP_SZ_BYTE;
      4'h3, 4'hC:             qfp_strb_size = QFP_SZ_WORD;
      4'hF:                   qfp_strb_size = QFP_SZ_DWORD;
      default:                qfp_strb_size = QFP_SZ_NONE;
    endcase
  endfunction : qfp_strb_size

  function automatic logic [2:0] qfp_size_bytes(input qfp_size_t sz);
    case (sz)
      QFP_SZ_BYTE:  qfp_size_bytes = 3'h1;
      QFP_SZ_WORD:  qfp_size_bytes = 3'h2;
      QFP_SZ_DWORD: qfp_size_bytes = 3'h4;
      default:      qfp_size_bytes = 3'h0;
    endcase
  endfunction : qfp_size_bytes

  // strobed lanes moved down so the first byte lands on the pointer
  function automatic logic [31:0] qfp_pack_wdata(input logic [3:0]  strb,
                                                 input logic [31:0] data);
    case (strb)
      4'h2:    qfp_pack_wdata = {24'h000000, data[15:8]};
      4'h4:    qfp_pack_wdata = {24'h000000, data[23:16]};
      4'h8:    qfp_pack_wdata = {24'h000000, data[31:24]};
      4'hC:    qfp_pack_wdata = {16'h0000, data[31:16]};
      default: qfp_pack_wdata = data;
    endcase
  endfunction : qfp_pack_wdata

  function automatic logic [31:0] qfp_mask_rdata(input qfp_size_t   sz,
                                                 input logic [31:0] data);
    case (sz)
      QFP_SZ_BYTE:  qfp_mask_rdata = {24'h000000, data[7:0]};
      QFP_SZ_WORD:  qfp_mask_rdata = {16'h0000, data[15:0]};
      QFP_SZ_DWORD: qfp_mask_rdata = data;
      default:      qfp_mask_rdata = 32'h00000000;
    endcase
  endfunction : qfp_mask_rdata

endpackage : qfp_pkg

// ### rtl/qfp_byte_ram.sv
// byte-wide queue frame memory with a four-byte host port and a far port
`timescale 1ns/1ns
`default_nettype none
module qfp_byte_ram #(
  parameter int AW = 11
) (
  input  wire logic          clk_in,          // system clock
  input  wire logic          rstn_in,         // sync reset, active low
  input  wire logic          host_wr_en_in,   // host write of 1..4 bytes
  input  wire logic [AW-1:0] host_wr_addr_in, // first byte address
  input  wire logic [2:0]    host_wr_cnt_in,  // byte count
  input  wire logic [31:0]   host_wr_data_in, // first byte in [7:0]
  input  wire logic [AW-1:0] host_rd_addr_in, // host read address
  output logic      [31:0]   host_rd_data_out,// four bytes from address
  input  wire logic          far_wr_en_in,    // far-side byte write
  input  wire logic [AW-1:0] far_wr_addr_in,  // far-side write address
  input  wire logic [7:0]    far_wr_data_in,  // far-side write byte
  input  wire logic [AW-1:0] far_rd_addr_in,  // far-side read address
  output logic      [7:0]    far_rd_data_out  // far-side byte, next cycle
);

  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] far_rd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // lanes follow the pointer and wrap at the top, so any alignment works
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      host_rd_data_out[8*i +: 8] = mem[host_rd_addr_in + AW'(i)];
    end
  end

  // the host write is last, so it wins a byte that both ports hit
  always_ff @(posedge clk_in) begin
    if (far_wr_en_in) begin
      mem[far_wr_addr_in] <= far_wr_data_in;
    end
    if (host_wr_en_in) begin
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < host_wr_cnt_in) begin
          mem[host_wr_addr_in + AW'(i)] <= host_wr_data_in[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      far_rd_ff <= 8'h00;
    end else begin
      far_rd_ff <= mem[far_rd_addr_in];
    end
  end

  assign far_rd_data_out = far_rd_ff;

endmodule : qfp_byte_ram
`default_nettype wire

// ### rtl/qfp_cmd_ctl.sv
// self-clearing queue command bit with a request pulse to the queue manager
`timescale 1ns/1ns
`default_nettype none
module qfp_cmd_ctl
  import qfp_pkg::*;
(
  input  wire logic clk_in,   // system clock
  input  wire logic rstn_in,  // sync reset, active low
  input  wire logic set_in,   // software wrote one to the bit
  input  wire logic done_in,  // queue manager finished the command
  output logic      busy_out, // bit as software reads it
  output logic      req_out   // one-cycle command pulse
);

  qfp_cmd_state_t state_ff;
  qfp_cmd_state_t nxt_state;
  logic           accept;

  ////////////////////////////////////////////////////////////////////////////
  // a write landing on the finishing cycle starts a new command: set wins
  assign accept = set_in & (~state_ff.busy | done_in);

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.busy = (state_ff.busy & ~done_in) | accept;
    nxt_state.req  = accept;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign busy_out = state_ff.busy;
  assign req_out  = state_ff.req;

endmodule : qfp_cmd_ctl
`default_nettype wire

// ### rtl/qfp_frame_port.sv
// host data port into the transmit and receive queue frame memories
//
// Behaviour
// - tx auto-increment advances pointer on data writes
// - step equals access size: 1, 2, 4
// - tx pointer holds when auto-increment clear
// - tx pointer: read/write bits 10:0, resets zero
// - enqueue completion reloads tx pointer
// - rx auto-increment advances pointer on data reads
// - rx pointer holds when auto-increment clear
// - rx pointer: read/write bits 10:0, resets zero
// - release completion reloads rx pointer
// - low data word: writes tx, reads rx
// - high data word: writes tx, reads rx
// - any pointer alignment transfers correctly
// - byte, word, dword accesses mix freely
// - low/high form one 32-bit location
// - enqueue bit queues frame, self-clears
// - release bit frees frame, self-clears
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "qfp_params.svh"
module qfp_frame_port
  import qfp_pkg::*;
(
  input  wire logic        CLK_SYS_IN,      // 10 MHz system clock
  input  wire logic        RSTN_IN,         // sync reset, active low
  input  wire logic [7:0]  AXI_AWADDR_IN,   // write address
  input  wire logic        AXI_AWVALID_IN,  // write address valid
  output logic             AXI_AWREADY_OUT, // write address ready
  input  wire logic [31:0] AXI_WDATA_IN,    // write data
  input  wire logic [3:0]  AXI_WSTRB_IN,    // write byte strobes
  input  wire logic        AXI_WVALID_IN,   // write data valid
  output logic             AXI_WREADY_OUT,  // write data ready
  output logic      [1:0]  AXI_BRESP_OUT,   // write response
  output logic             AXI_BVALID_OUT,  // write response valid
  input  wire logic        AXI_BREADY_IN,   // write response ready
  input  wire logic [7:0]  AXI_ARADDR_IN,   // read address
  input  wire logic        AXI_ARVALID_IN,  // read address valid
  output logic             AXI_ARREADY_OUT, // read address ready
  output logic      [31:0] AXI_RDATA_OUT,   // read data
  output logic      [1:0]  AXI_RRESP_OUT,   // read response
  output logic             AXI_RVALID_OUT,  // read data valid
  input  wire logic        AXI_RREADY_IN,   // read data ready
  input  wire logic [10:0] TXQ_RD_ADDR_IN,  // manager read of tx queue
  output logic      [7:0]  TXQ_RD_DATA_OUT, // tx queue byte, next cycle
  output logic             ENQ_REQ_OUT,     // enqueue command pulse
  input  wire logic        ENQ_DONE_IN,     // frame sent, pointer valid
  input  wire logic [10:0] TX_NEXT_PTR_IN,  // next free tx frame location
  input  wire logic        RXQ_WR_EN_IN,    // manager write of rx queue
  input  wire logic [10:0] RXQ_WR_ADDR_IN,  // rx queue write address
  input  wire logic [7:0]  RXQ_WR_DATA_IN,  // rx queue write byte
  output logic             REL_REQ_OUT,     // release command pulse
  input  wire logic        REL_DONE_IN,     // frame freed, pointer valid
  input  wire logic [10:0] RX_NEXT_PTR_IN   // next rx frame location
);

  qfp_state_t  state_ff;
  qfp_state_t  nxt_state;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_word;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        do_wr;
  logic        do_rd;
  qfp_size_t   wsize;
  qfp_size_t   rsize;
  logic [7:0]  rd_word;
  logic        w_txcmd;
  logic        w_rxcmd;
  logic        w_txptr;
  logic        w_rxptr;
  logic        w_data;
  logic        w_map;
  logic        tx_wr_en;
  logic        rx_step;
  logic [10:0] tx_ptr_plus;
  logic [10:0] rx_ptr_plus;
  logic [31:0] rx_word;
  logic [31:0] rd_value;
  logic [1:0]  rd_resp;
  logic        enq_busy;
  logic        rel_busy;
  logic        enq_done;
  logic        rel_done;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data are taken in either order
  assign wr_addr = state_ff.aw_got ? state_ff.aw_addr : AXI_AWADDR_IN;
  assign wr_data = state_ff.w_got ? state_ff.w_data : AXI_WDATA_IN;
  assign wr_strb = state_ff.w_got ? state_ff.w_strb : AXI_WSTRB_IN;
  assign wr_word = {wr_addr[7:2], 2'h0};
  assign do_wr   = (state_ff.aw_got | AXI_AWVALID_IN)
                 & (state_ff.w_got | AXI_WVALID_IN) & ~state_ff.bvalid;
  assign AXI_AWREADY_OUT = ~state_ff.aw_got & ~state_ff.bvalid;
  assign AXI_WREADY_OUT  = ~state_ff.w_got & ~state_ff.bvalid;

  assign w_txcmd = do_wr & (wr_word == `QFP_ADDR(`QFP_IDX_TXCMD));
  assign w_rxcmd = do_wr & (wr_word == `QFP_ADDR(`QFP_IDX_RXCMD));
  assign w_txptr = do_wr & (wr_word == `QFP_ADDR(`QFP_IDX_TXPTR));
  assign w_rxptr = do_wr & (wr_word == `QFP_ADDR(`QFP_IDX_RXPTR));
  // both data words take writes: a 16-bit host alternates them
  assign w_data  = do_wr & ((wr_word == `QFP_ADDR(`QFP_IDX_DATLO))
                         | (wr_word == `QFP_ADDR(`QFP_IDX_DATHI)));
  assign w_map   = w_txcmd | w_rxcmd | w_txptr | w_rxptr | w_data
                 | (wr_word == `QFP_ADDR(`QFP_IDX_RDBYTE));
  // size comes from the strobes of each access
  assign wsize    = qfp_strb_size(wr_strb);
  assign tx_wr_en = w_data & (wsize != QFP_SZ_NONE);
  assign tx_ptr_plus = state_ff.tx_ptr + 11'(qfp_size_bytes(wsize));

  ////////////////////////////////////////////////////////////////////////////
  // read channel: the word address picks the read size
  assign do_rd           = AXI_ARVALID_IN & ~state_ff.rvalid;
  assign AXI_ARREADY_OUT = ~state_ff.rvalid;
  assign rd_word         = {AXI_ARADDR_IN[7:2], 2'h0};

  always_comb begin
    rsize    = QFP_SZ_NONE;
    rd_value = 32'h00000000;
    rd_resp  = `QFP_RESP_OKAY;
    if (rd_word == `QFP_ADDR(`QFP_IDX_TXCMD)) begin
      rd_value[`QFP_CMD_BIT] = enq_busy;
    end else if (rd_word == `QFP_ADDR(`QFP_IDX_RXCMD)) begin
      rd_value[`QFP_CMD_BIT] = rel_busy;
    end else if (rd_word == `QFP_ADDR(`QFP_IDX_TXPTR)) begin
      rd_value[`QFP_AI_BIT]     = state_ff.tx_ai;
      rd_value[`QFP_PTR_MSB:0] = state_ff.tx_ptr;
    end else if (rd_word == `QFP_ADDR(`QFP_IDX_RXPTR)) begin
      rd_value[`QFP_AI_BIT]     = state_ff.rx_ai;
      rd_value[`QFP_PTR_MSB:0] = state_ff.rx_ptr;
    end else if (rd_word == `QFP_ADDR(`QFP_IDX_DATLO)) begin
      rsize = QFP_SZ_DWORD;
    end else if (rd_word == `QFP_ADDR(`QFP_IDX_DATHI)) begin
      rsize = QFP_SZ_WORD;
    end else if (rd_word == `QFP_ADDR(`QFP_IDX_RDBYTE)) begin
      rsize = QFP_SZ_BYTE;
    end else begin
      rd_resp = `QFP_RESP_DECERR;
    end
    if (rsize != QFP_SZ_NONE) begin
      rd_value = qfp_mask_rdata(rsize, rx_word);
    end
  end

  assign rx_step     = do_rd & (rsize != QFP_SZ_NONE);
  assign rx_ptr_plus = state_ff.rx_ptr + 11'(qfp_size_bytes(rsize));
  // a reload is only honoured while its command is still pending
  assign enq_done    = ENQ_DONE_IN & enq_busy;
  assign rel_done    = REL_DONE_IN & rel_busy;

  ////////////////////////////////////////////////////////////////////////////
  // bus channel and pointer state; software pointer writes beat reloads beat increments
  always_comb begin
    nxt_state = state_ff;
    if (AXI_AWVALID_IN & AXI_AWREADY_OUT & ~do_wr) begin
      nxt_state.aw_got  = 1'b1;
      nxt_state.aw_addr = AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN & AXI_WREADY_OUT & ~do_wr) begin
      nxt_state.w_got  = 1'b1;
      nxt_state.w_data = AXI_WDATA_IN;
      nxt_state.w_strb = AXI_WSTRB_IN;
    end
    if (do_wr) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      if (!w_map) begin
        nxt_state.bresp = `QFP_RESP_DECERR;
      end else if (w_data & (wsize == QFP_SZ_NONE)) begin
        nxt_state.bresp = `QFP_RESP_SLVERR;
      end else begin
        nxt_state.bresp = `QFP_RESP_OKAY;
      end
    end else if (state_ff.bvalid & AXI_BREADY_IN) begin
      nxt_state.bvalid = 1'b0;
    end

    if (w_txptr) begin
      if (wr_strb[0]) begin
        nxt_state.tx_ptr[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
        nxt_state.tx_ai                   = wr_data[`QFP_AI_BIT];
        nxt_state.tx_ptr[`QFP_PTR_MSB:8] = wr_data[`QFP_PTR_MSB:8];
      end
    end else if (enq_done) begin
      nxt_state.tx_ptr = TX_NEXT_PTR_IN;
    end else if (tx_wr_en & state_ff.tx_ai) begin
      nxt_state.tx_ptr = tx_ptr_plus;
    end

    if (w_rxptr) begin
      if (wr_strb[0]) begin
        nxt_state.rx_ptr[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
        nxt_state.rx_ai                   = wr_data[`QFP_AI_BIT];
        nxt_state.rx_ptr[`QFP_PTR_MSB:8] = wr_data[`QFP_PTR_MSB:8];
      end
    end else if (rel_done) begin
      nxt_state.rx_ptr = RX_NEXT_PTR_IN;
    end else if (rx_step & state_ff.rx_ai) begin
      nxt_state.rx_ptr = rx_ptr_plus;
    end

    if (do_rd) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata  = rd_value;
      nxt_state.rresp  = rd_resp;
    end else if (state_ff.rvalid & AXI_RREADY_IN) begin
      nxt_state.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      state_ff        <= '0;
      state_ff.tx_ai  <= `QFP_AI_RST;
      state_ff.tx_ptr <= `QFP_PTR_RST;
      state_ff.rx_ai  <= `QFP_AI_RST;
      state_ff.rx_ptr <= `QFP_PTR_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign AXI_BVALID_OUT = state_ff.bvalid;
  assign AXI_BRESP_OUT  = state_ff.bresp;
  assign AXI_RVALID_OUT = state_ff.rvalid;
  assign AXI_RDATA_OUT  = state_ff.rdata;
  assign AXI_RRESP_OUT  = state_ff.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // queue memories and command bits
  qfp_byte_ram #(.AW(`QFP_PTR_W)) u_tx_ram (
    .clk_in           (CLK_SYS_IN),
    .rstn_in          (RSTN_IN),
    .host_wr_en_in    (tx_wr_en),
    .host_wr_addr_in  (state_ff.tx_ptr),
    .host_wr_cnt_in   (qfp_size_bytes(wsize)),
    .host_wr_data_in  (qfp_pack_wdata(wr_strb, wr_data)),
    .host_rd_addr_in  (state_ff.tx_ptr),
    .host_rd_data_out (),
    .far_wr_en_in     (1'b0),
    .far_wr_addr_in   (`QFP_PTR_RST),
    .far_wr_data_in   (8'h00),
    .far_rd_addr_in   (TXQ_RD_ADDR_IN),
    .far_rd_data_out  (TXQ_RD_DATA_OUT)
  );

  qfp_byte_ram #(.AW(`QFP_PTR_W)) u_rx_ram (
    .clk_in           (CLK_SYS_IN),
    .rstn_in          (RSTN_IN),
    .host_wr_en_in    (1'b0),
    .host_wr_addr_in  (`QFP_PTR_RST),
    .host_wr_cnt_in   (3'h0),
    .host_wr_data_in  (32'h00000000),
    .host_rd_addr_in  (state_ff.rx_ptr),
    .host_rd_data_out (rx_word),
    .far_wr_en_in     (RXQ_WR_EN_IN),
    .far_wr_addr_in   (RXQ_WR_ADDR_IN),
    .far_wr_data_in   (RXQ_WR_DATA_IN),
    .far_rd_addr_in   (`QFP_PTR_RST),
    .far_rd_data_out  ()
  );

  qfp_cmd_ctl u_enq_cmd (
    .clk_in   (CLK_SYS_IN),
    .rstn_in  (RSTN_IN),
    .set_in   (w_txcmd & wr_strb[0] & wr_data[`QFP_CMD_BIT]),
    .done_in  (ENQ_DONE_IN),
    .busy_out (enq_busy),
    .req_out  (ENQ_REQ_OUT)
  );

  qfp_cmd_ctl u_rel_cmd (
    .clk_in   (CLK_SYS_IN),
    .rstn_in  (RSTN_IN),
    .set_in   (w_rxcmd & wr_strb[0] & wr_data[`QFP_CMD_BIT]),
    .done_in  (REL_DONE_IN),
    .busy_out (rel_busy),
    .req_out  (REL_REQ_OUT)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);

  chk_tx_auto_step: assert property (
    tx_wr_en & state_ff.tx_ai & ~w_txptr & ~enq_done
    |=> state_ff.tx_ptr == $past(state_ff.tx_ptr)
        + 11'($countones($past(wr_strb))))
    else $error("tx pointer did not advance by the access size");

  chk_step_size: assert property (
    tx_wr_en |-> qfp_size_bytes(wsize) == 3'($countones(wr_strb)))
    else $error("write step differs from byte count");

  chk_tx_ptr_hold: assert property (
    ~state_ff.tx_ai & ~w_txptr & ~enq_done |=> $stable(state_ff.tx_ptr))
    else $error("tx pointer moved without auto increment");

  chk_rx_auto_step: assert property (
    do_rd & (rd_word == `QFP_ADDR(`QFP_IDX_DATLO)) & state_ff.rx_ai
    & ~w_rxptr & ~rel_done
    |=> state_ff.rx_ptr == $past(state_ff.rx_ptr) + 11'h004)
    else $error("rx pointer did not advance by four");

  chk_rx_ptr_hold: assert property (
    ~state_ff.rx_ai & ~w_rxptr & ~rel_done |=> $stable(state_ff.rx_ptr))
    else $error("rx pointer moved without auto increment");

  chk_enq_reload: assert property (
    ENQ_DONE_IN & enq_busy & ~w_txptr
    |=> state_ff.tx_ptr == $past(TX_NEXT_PTR_IN))
    else $error("tx pointer not reloaded after enqueue");

  chk_rel_reload: assert property (
    REL_DONE_IN & rel_busy & ~w_rxptr
    |=> state_ff.rx_ptr == $past(RX_NEXT_PTR_IN))
    else $error("rx pointer not reloaded after release");

  chk_ptr_reserved: assert property (
    do_rd & ((rd_word == `QFP_ADDR(`QFP_IDX_TXPTR))
           | (rd_word == `QFP_ADDR(`QFP_IDX_RXPTR)))
    |=> AXI_RVALID_OUT && AXI_RDATA_OUT[31:15] == 17'h00000
        && AXI_RDATA_OUT[13:11] == 3'h0)
    else $error("reserved pointer bits not zero");

  chk_rx_data_word: assert property (
    do_rd & (rd_word == `QFP_ADDR(`QFP_IDX_DATHI))
    |=> AXI_RDATA_OUT == {16'h0000, $past(rx_word[15:0])})
    else $error("high data read not from rx pointer");

  chk_enq_self_clear: assert property (
    ENQ_REQ_OUT |-> enq_busy ##1 !ENQ_REQ_OUT)
    else $error("enqueue pulse longer than one cycle");

  chk_rel_hold: assert property (
    rel_busy & ~REL_DONE_IN |=> rel_busy)
    else $error("release bit cleared before completion");

  chk_wr_answer: assert property (
    do_wr |=> AXI_BVALID_OUT ##0 !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("write answer not one cycle after transfer");

  cov_dword_write: cover property (tx_wr_en & (wsize == QFP_SZ_DWORD));
  cov_byte_read:   cover property (rx_step & (rsize == QFP_SZ_BYTE));
  cov_enq_done:    cover property (enq_done);
  cov_ptr_wrap:    cover property (
    tx_wr_en & state_ff.tx_ai & (state_ff.tx_ptr == 11'h7FF));

endmodule : qfp_frame_port
`default_nettype wire

// ### tb/qfp_qm_model.sv
// queue manager model: finishes enqueue and release after a delay
`timescale 1ns/1ns
`default_nettype none
module qfp_qm_model #(
  parameter int          DLY = 6,
  parameter logic [10:0] TXN = 11'h1F0,
  parameter logic [10:0] RXN = 11'h2A4
) (
  input  wire logic        clk_in,       // system clock
  input  wire logic        enq_req_in,   // enqueue pulse
  input  wire logic        rel_req_in,   // release pulse
  output logic             enq_done_out, // enqueue finished
  output logic             rel_done_out, // release finished
  output logic      [10:0] tx_next_out,  // next tx frame start
  output logic      [10:0] rx_next_out   // next rx frame start
);
  // pointer lines carry junk outside the done pulse, never a stale value
  initial begin
    enq_done_out = 1'b0;
    rel_done_out = 1'b0;
    tx_next_out = ~TXN;
    rx_next_out = ~RXN;
  end
  always @(posedge clk_in) begin
    if (enq_req_in) begin
      repeat (DLY) @(posedge clk_in);
      enq_done_out <= 1'b1;
      tx_next_out <= TXN;
      @(posedge clk_in);
      enq_done_out <= 1'b0;
      tx_next_out <= ~TXN;
    end
  end
  always @(posedge clk_in) begin
    if (rel_req_in) begin
      repeat (DLY) @(posedge clk_in);
      rel_done_out <= 1'b1;
      rx_next_out <= RXN;
      @(posedge clk_in);
      rel_done_out <= 1'b0;
      rx_next_out <= ~RXN;
    end
  end
endmodule : qfp_qm_model
`default_nettype wire

// ### tb/qfp_frame_port_tb_top.sv
// self-checking bench for the queue frame data port
`timescale 1ns/1ns
`default_nettype none
`include "qfp_params.svh"
module qfp_frame_port_tb_top;
  localparam logic [10:0] TXN = 11'h1F0;
  localparam logic [10:0] RXN = 11'h2A4;
  localparam logic [1:0]  OK = `QFP_RESP_OKAY;
  localparam logic [7:0]  TC = `QFP_ADDR(`QFP_IDX_TXCMD),
    RC = `QFP_ADDR(`QFP_IDX_RXCMD), TP = `QFP_ADDR(`QFP_IDX_TXPTR),
    RP = `QFP_ADDR(`QFP_IDX_RXPTR), DL = `QFP_ADDR(`QFP_IDX_DATLO),
    DH = `QFP_ADDR(`QFP_IDX_DATHI), RB = `QFP_ADDR(`QFP_IDX_RDBYTE);
  logic        clk, rstn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic        eq, ed, rq, rdn, rxwe;
  logic [1:0]  bresp, rresp;
  logic [3:0]  strb;
  logic [7:0]  awa, ara, txd, rxwd;
  logic [10:0] txra, rxwa, txn, rxn;
  logic [31:0] wdat, rdat, d;
  int          num_errors, cmp_count, cyc;

  qfp_frame_port dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
    .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
    .AXI_WDATA_IN(wdat), .AXI_WSTRB_IN(strb), .AXI_WVALID_IN(wv),
    .AXI_WREADY_OUT(wrdy), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bv),
    .AXI_BREADY_IN(br), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv),
    .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rresp),
    .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rr), .TXQ_RD_ADDR_IN(txra),
    .TXQ_RD_DATA_OUT(txd), .ENQ_REQ_OUT(eq), .ENQ_DONE_IN(ed),
    .TX_NEXT_PTR_IN(txn), .RXQ_WR_EN_IN(rxwe), .RXQ_WR_ADDR_IN(rxwa),
    .RXQ_WR_DATA_IN(rxwd), .REL_REQ_OUT(rq), .REL_DONE_IN(rdn),
    .RX_NEXT_PTR_IN(rxn));
  qfp_qm_model #(.TXN(TXN), .RXN(RXN)) qm (.clk_in(clk), .enq_req_in(eq),
    .rel_req_in(rq), .enq_done_out(ed), .rel_done_out(rdn),
    .tx_next_out(txn), .rx_next_out(rxn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      complete_run();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] %0t saw %h expected %h", $time, s, x);
    end
  endtask : check
  // valid and payload held until own ready; bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s, input logic [1:0] e);
    awa <= a;
    wdat <= v;
    strb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    // bready stays high, so a following call never drives it twice at once
    check({30'h0, bresp}, {30'h0, e});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] e);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    check({30'h0, rresp}, {30'h0, e});
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    rd(a, OK);
    check(d, x);
  endtask : rdc
  task automatic txq_chk(input logic [10:0] a, input logic [7:0] x);
    txra <= a;
    repeat (2) @(posedge clk);
    check({24'h0, txd}, {24'h0, x});
  endtask : txq_chk
  // polls the self-clearing command bit, bounded
  task automatic wait_clear(input logic [7:0] a);
    int k;
    k = 0;
    do begin
      rd(a, OK);
      k++;
    end while (d[0] !== 1'b0 && k < 20);
    check(d, 32'h0);
  endtask : wait_clear
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rstn, awv, wv, br, arv, rr, rxwe} = '0;
    {awa, ara, wdat, strb, txra, rxwa, rxwd} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(TP, 32'h0);
    rdc(RP, 32'h0);
    wr(TP, 32'hFFFFFFFF, 4'hF, OK);
    rdc(TP, 32'h000047FF);
    wr(8'h40, 32'h1, 4'hF, `QFP_RESP_DECERR);
    rd(8'h40, `QFP_RESP_DECERR);
    $display("test registers done");
    wr(TP, 32'h47FD, 4'h3, OK);
    wr(DL, 32'hAA, 4'h1, OK);
    wr(DL, 32'hCCBB, 4'h3, OK);
    wr(DL, 32'h44332211, 4'hF, OK);
    wr(DH, 32'h55660000, 4'hC, OK);
    wr(DL, 32'h0, 4'h5, `QFP_RESP_SLVERR);
    rdc(TP, 32'h00004006);
    txq_chk(11'h7FD, 8'hAA);
    txq_chk(11'h7FF, 8'hCC);
    txq_chk(11'h000, 8'h11);
    txq_chk(11'h005, 8'h55);
    wr(TP, 32'h0010, 4'h3, OK);
    wr(DL, 32'h0, 4'hF, OK);
    rdc(TP, 32'h0010);
    $display("test transmit done");
    rxwe <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rxwa <= 11'h7FE + 11'(i);
      rxwd <= 8'hA0 + 8'(i);
      @(posedge clk);
    end
    rxwe <= 1'b0;
    wr(RP, 32'h47FE, 4'h3, OK);
    rdc(DL, 32'hA3A2A1A0);
    rdc(DH, 32'h0000A5A4);
    rdc(RB, 32'h000000A6);
    rdc(RP, 32'h00004005);
    wr(RP, 32'h0001, 4'h3, OK);
    rdc(DL, 32'hA6A5A4A3);
    rdc(RP, 32'h0001);
    $display("test receive done");
    wr(TC, 32'h1, 4'h1, OK);
    rdc(TC, 32'h1);
    wait_clear(TC);
    rdc(TP, {21'h0, TXN});
    wr(RC, 32'h1, 4'h1, OK);
    rdc(RC, 32'h1);
    wait_clear(RC);
    rdc(RP, {21'h0, RXN});
    $display("test commands done");
    // pointers hold reload values here, so a mid-run reset must clear them
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(TP, 32'h0);
    rdc(RP, 32'h0);
    rdc(TC, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule : qfp_frame_port_tb_top
`default_nettype wire
